// ===== hdl/csid_pkg.sv
// Shared constants and types of the system-instruction decode unit.
package csid_pkg;

	// ----------------------------------------------------------------
	// Opcode bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] BYTE_ADDR_FLIP = 8'h67; // Address width prefix.
	localparam logic [7:0] BYTE_OPND_FLIP = 8'h66; // Operand width prefix.
	localparam logic [7:0] BYTE_ESCAPE = 8'h0f; // Two-byte opcode escape.
	localparam logic [7:0] BYTE_ADJ_PRIV = 8'h63; // Privilege adjust.
	localparam logic [7:0] SEC_CR_WR = 8'h22; // Control reg zero load.
	localparam logic [7:0] SEC_CR_RD = 8'h20; // Control reg zero store.
	localparam logic [7:0] SEC_DR_WR = 8'h23; // Debug register load.
	localparam logic [7:0] SEC_DR_RD = 8'h21; // Debug register store.
	localparam logic [7:0] SEC_CLR_TS = 8'h06; // Clear task switched.
	localparam logic [7:0] SEC_ACC_RIGHTS = 8'h02; // Access rights.
	localparam logic [7:0] SEC_SEG_LIMIT = 8'h03; // Segment limit.
	localparam logic [7:0] SEC_GROUP1 = 8'h01; // Table and status group.
	localparam logic [7:0] SEC_GROUP0 = 8'h00; // Local table, task group.

	// ----------------------------------------------------------------
	// ModR/M fields
	// ----------------------------------------------------------------
	localparam int MOD_HI = 7; // Mod field upper bit.
	localparam int MOD_LO = 6; // Mod field lower bit.
	localparam int REG_HI = 5; // Reg field upper bit.
	localparam int REG_LO = 3; // Reg field lower bit.
	localparam logic [1:0] MOD_REGISTER = 2'h3; // Register operand form.
	localparam logic [2:0] REG_GLOBAL = 3'h2; // Group 1 global table.
	localparam logic [2:0] REG_INTR = 3'h3; // Group 1 interrupt table.
	localparam logic [2:0] REG_MSW = 3'h6; // Group 1 machine status.
	localparam logic [2:0] REG_LOCAL = 3'h2; // Group 0 local table.
	localparam logic [2:0] REG_TASK = 3'h3; // Group 0 task register.
	localparam logic [2:0] REG_CR_ZERO = 3'h0; // Control register zero.
	localparam logic [2:0] REG_DR_GAP_A = 3'h4; // Absent debug register.
	localparam logic [2:0] REG_DR_GAP_B = 3'h5; // Absent debug register.

	// ----------------------------------------------------------------
	// Execution cycle counts
	// ----------------------------------------------------------------
	localparam logic [3:0] CYC_PREFIX = 4'h1;
	localparam logic [3:0] CYC_CR_WR = 4'h5;
	localparam logic [3:0] CYC_CR_RD = 4'h1;
	localparam logic [3:0] CYC_DR_WR = 4'h4;
	localparam logic [3:0] CYC_DR_RD = 4'h3;
	localparam logic [3:0] CYC_CLR_TS = 4'h5;
	localparam logic [3:0] CYC_ADJ_REG_MIN = 4'h8;
	localparam logic [3:0] CYC_ADJ_REG_MAX = 4'ha;
	localparam logic [3:0] CYC_ADJ_MEM_MIN = 4'h6;
	localparam logic [3:0] CYC_ADJ_MEM_MAX = 4'h8;
	localparam logic [3:0] CYC_ACC_REG_MIN = 4'h3;
	localparam logic [3:0] CYC_ACC_REG_MAX = 4'h5;
	localparam logic [3:0] CYC_ACC_MEM_MIN = 4'h5;
	localparam logic [3:0] CYC_ACC_MEM_MAX = 4'h7;
	localparam logic [3:0] CYC_GLOBAL = 4'h4;
	localparam logic [3:0] CYC_INTR = 4'h4;
	localparam logic [3:0] CYC_LOC_REG_MIN = 4'h5;
	localparam logic [3:0] CYC_LOC_REG_MAX = 4'h8;
	localparam logic [3:0] CYC_LOC_MEM_MIN = 4'h6;
	localparam logic [3:0] CYC_LOC_MEM_MAX = 4'h9;
	localparam logic [3:0] CYC_MSW_REG = 4'h5;
	localparam logic [3:0] CYC_MSW_MEM = 4'h7;
	localparam logic [3:0] CYC_LIM_REG_MIN = 4'h3;
	localparam logic [3:0] CYC_LIM_REG_MAX = 4'h7;
	localparam logic [3:0] CYC_LIM_MEM_MIN = 4'h5;
	localparam logic [3:0] CYC_LIM_MEM_MAX = 4'h9;
	localparam logic [3:0] CYC_TASK_REG = 4'h8;
	localparam logic [3:0] CYC_TASK_MEM = 4'h9;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Decoded operation; the two group entries live between bytes and stay after a rejected ModR/M byte.
	typedef enum logic [3:0] {
		OP_NONE, OP_CR_WR, OP_CR_RD, OP_DR_WR, OP_DR_RD, OP_CLR_TS,
		OP_ADJ_PRIV, OP_ACC_RIGHTS, OP_GLOBAL, OP_INTR, OP_LOCAL,
		OP_MSW, OP_SEG_LIMIT, OP_TASK, OP_GROUP0, OP_GROUP1
	} csid_op_t;

	// Byte sequencer states.
	typedef enum logic [1:0] {ST_FIRST, ST_SECOND, ST_MODRM, ST_EXEC}
		csid_state_t;

endpackage

// ===== hdl/csid_tmr_if.sv
// Carrier between the decode sequencer and its execution timer.
interface csid_tmr_if;
	logic load; // Start a stall of load_val cycles.
	logic [3:0] load_val; // Stall length in cycles.
	logic busy; // Stall still running.
	logic last; // Final stall cycle.
	modport ctl (output load, output load_val, input busy, input last);
	modport tmr (input load, input load_val, output busy, output last);
endinterface

// ===== hdl/csid_exec_timer.sv
// Down-counter that holds an instruction for its stall cycles.
module csid_exec_timer
	import csid_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	csid_tmr_if.tmr t
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] cnt; // Stall cycles still to run.
	} csid_tmr_st_t;

	csid_tmr_st_t s_r; // Registered state.
	csid_tmr_st_t s_nxt; // Next state.

	// A new load always wins, so a stall can be restarted at once.
	always_comb begin
		s_nxt = s_r;
		if (t.load) begin
			s_nxt.cnt = t.load_val;
		end else if (s_r.cnt != 4'h0) begin
			s_nxt.cnt = s_r.cnt - 4'h1;
		end
	end

	// State register.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign t.busy = s_r.cnt != 4'h0;
	assign t.last = s_r.cnt == 4'h1;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_tmr_load: assert property (@(posedge clk) disable iff (rst)
		t.load && t.load_val == 4'h3 |=> t.busy ##1 t.busy ##1 t.last
		##1 !t.busy)
		else $error("Timer stall length wrong.");

endmodule

// ===== hdl/csid_decode.sv
// Decode and timing unit for processor and protection control opcodes.
//
// Functional notes
// - Address width prefix costs one cycle
// - Operand width prefix costs one cycle
// - Control reg zero load 5, store 1
// - Debug register load 4, store 3
// - Clear task switched takes 5 cycles
// - Privilege adjust register 8/10, memory 6/8
// - Access rights register 3/5, memory 5/7
// - Global table load from memory, 4 cycles
// - Interrupt table load from memory, 4 cycles
// - Local table load register 5/8, memory 6/9
// - Machine status load register 5, memory 7
// - Segment limit register 3/7, memory 5/9
// - Task register load register 8, memory 9
module csid_decode
	import csid_pkg::*;
(
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	input wire logic BYTE_VALID,
	input wire logic [7:0] BYTE_DATA,
	input wire logic EXEC_SLOW,
	output logic BYTE_READY,
	output logic BUSY,
	output logic EA_REQ,
	output logic INSTR_DONE,
	output logic INSTR_ILLEGAL,
	output logic [3:0] INSTR_OP,
	output logic INSTR_MEM,
	output logic INSTR_ADDR_FLIP,
	output logic INSTR_OPND_FLIP,
	output logic [3:0] INSTR_CYCLES
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		csid_state_t st; // Byte sequencer position.
		csid_op_t op; // Operation being assembled.
		logic addr_flip; // Address width prefix seen.
		logic opnd_flip; // Operand width prefix seen.
		logic mem; // Memory operand form.
		logic [3:0] cycles; // Cycles charged to the instruction.
		logic done; // Completion pulse.
		logic illegal; // Rejected encoding pulse.
		logic ea; // Address generation pulse.
		logic addr_out; // Address flip reported with completion.
		logic opnd_out; // Operand flip reported with completion.
		logic [3:0] lat; // Cycles since the last final byte, for checks.
	} csid_dec_st_t;

	csid_dec_st_t s_r; // Registered state.
	csid_dec_st_t s_nxt; // Next state.
	csid_tmr_if tmr (); // Link to the stall timer.

	logic take; // A byte is accepted this cycle.
	logic fire; // The final byte of an instruction is accepted.
	csid_op_t fire_op; // Operation resolved by the final byte.
	logic fire_mem; // Form resolved by the final byte.
	logic [3:0] fire_cyc; // Cycle count of that operation.
	logic [1:0] mod_f; // ModR/M mod field of the current byte.
	logic [2:0] reg_f; // ModR/M reg field of the current byte.

	// Cycle count per operation; min or max chosen by the slow input.
	function automatic logic [3:0] cyc_of(csid_op_t op, logic mem,
		logic slow);
		logic [3:0] c;
		c = CYC_PREFIX;
		case (op)
			OP_CR_WR: c = CYC_CR_WR;
			OP_CR_RD: c = CYC_CR_RD;
			OP_DR_WR: c = CYC_DR_WR;
			OP_DR_RD: c = CYC_DR_RD;
			OP_CLR_TS: c = CYC_CLR_TS;
			OP_ADJ_PRIV: c = mem ? (slow ? CYC_ADJ_MEM_MAX : CYC_ADJ_MEM_MIN)
				: (slow ? CYC_ADJ_REG_MAX : CYC_ADJ_REG_MIN);
			OP_ACC_RIGHTS: c = mem ? (slow ? CYC_ACC_MEM_MAX : CYC_ACC_MEM_MIN)
				: (slow ? CYC_ACC_REG_MAX : CYC_ACC_REG_MIN);
			OP_GLOBAL: c = CYC_GLOBAL;
			OP_INTR: c = CYC_INTR;
			OP_LOCAL: c = mem ? (slow ? CYC_LOC_MEM_MAX : CYC_LOC_MEM_MIN)
				: (slow ? CYC_LOC_REG_MAX : CYC_LOC_REG_MIN);
			OP_MSW: c = mem ? CYC_MSW_MEM : CYC_MSW_REG;
			OP_SEG_LIMIT: c = mem ? (slow ? CYC_LIM_MEM_MAX : CYC_LIM_MEM_MIN)
				: (slow ? CYC_LIM_REG_MAX : CYC_LIM_REG_MIN);
			OP_TASK: c = mem ? CYC_TASK_MEM : CYC_TASK_REG;
			default: c = CYC_PREFIX;
		endcase
		return c;
	endfunction

	// ----------------------------------------------------------------
	// Handshake
	// ----------------------------------------------------------------
	// Bytes are refused only while an instruction stalls.
	assign BYTE_READY = s_r.st != ST_EXEC;
	assign take = BYTE_VALID && BYTE_READY;
	assign mod_f = BYTE_DATA[MOD_HI:MOD_LO];
	assign reg_f = BYTE_DATA[REG_HI:REG_LO];

	// ----------------------------------------------------------------
	// Final-byte resolution
	// ----------------------------------------------------------------
	// Works out which operation, if any, the byte on the bus completes.
	always_comb begin
		fire_op = OP_NONE;
		fire_mem = mod_f != MOD_REGISTER;
		if (s_r.st == ST_SECOND && BYTE_DATA == SEC_CLR_TS) begin
			fire_op = OP_CLR_TS;
			fire_mem = 1'b0;
		end else if (s_r.st == ST_MODRM) begin
			case (s_r.op)
				// Control and debug moves exist only in register form.
				OP_CR_WR, OP_CR_RD: begin
					if (!fire_mem && reg_f == REG_CR_ZERO) begin
						fire_op = s_r.op;
					end
				end
				OP_DR_WR, OP_DR_RD: begin
					if (!fire_mem && reg_f != REG_DR_GAP_A
						&& reg_f != REG_DR_GAP_B) begin
						fire_op = s_r.op;
					end
				end
				OP_GROUP1: begin
					if (reg_f == REG_GLOBAL && fire_mem) begin
						fire_op = OP_GLOBAL;
					end else if (reg_f == REG_INTR && fire_mem) begin
						fire_op = OP_INTR;
					end else if (reg_f == REG_MSW) begin
						fire_op = OP_MSW;
					end
				end
				OP_GROUP0: begin
					if (reg_f == REG_LOCAL) begin
						fire_op = OP_LOCAL;
					end else if (reg_f == REG_TASK) begin
						fire_op = OP_TASK;
					end
				end
				default: begin
					fire_op = s_r.op;
				end
			endcase
		end
	end

	assign fire = take && fire_op != OP_NONE;
	assign fire_cyc = cyc_of(fire_op, fire_mem, EXEC_SLOW);

	// ----------------------------------------------------------------
	// Sequencer
	// ----------------------------------------------------------------
	// Steps through prefix, opcode and ModR/M bytes, then stalls.
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		s_nxt.illegal = 1'b0;
		s_nxt.ea = 1'b0;
		s_nxt.lat = fire ? 4'h1 : s_r.lat + 4'h1;
		tmr.load = 1'b0;
		tmr.load_val = fire_cyc - 4'h1;
		if (fire) begin
			// The accept cycle is the first charged cycle.
			s_nxt.op = fire_op;
			s_nxt.mem = fire_mem;
			s_nxt.cycles = fire_cyc;
			s_nxt.ea = fire_mem;
			// Flags shown with completion are those held before clearing.
			s_nxt.addr_out = s_r.addr_flip;
			s_nxt.opnd_out = s_r.opnd_flip;
			if (fire_cyc == 4'h1) begin
				s_nxt.done = 1'b1;
				s_nxt.st = ST_FIRST;
			end else begin
				tmr.load = 1'b1;
				s_nxt.st = ST_EXEC;
			end
		end else if (take) begin
			case (s_r.st)
				ST_FIRST: begin
					if (BYTE_DATA == BYTE_ADDR_FLIP) begin
						s_nxt.addr_flip = 1'b1;
					end else if (BYTE_DATA == BYTE_OPND_FLIP) begin
						s_nxt.opnd_flip = 1'b1;
					end else if (BYTE_DATA == BYTE_ESCAPE) begin
						s_nxt.st = ST_SECOND;
					end else if (BYTE_DATA == BYTE_ADJ_PRIV) begin
						s_nxt.op = OP_ADJ_PRIV;
						s_nxt.st = ST_MODRM;
					end else begin
						s_nxt.illegal = 1'b1;
					end
				end
				ST_SECOND: begin
					s_nxt.st = ST_MODRM;
					case (BYTE_DATA)
						SEC_CR_WR: s_nxt.op = OP_CR_WR;
						SEC_CR_RD: s_nxt.op = OP_CR_RD;
						SEC_DR_WR: s_nxt.op = OP_DR_WR;
						SEC_DR_RD: s_nxt.op = OP_DR_RD;
						SEC_ACC_RIGHTS: s_nxt.op = OP_ACC_RIGHTS;
						SEC_SEG_LIMIT: s_nxt.op = OP_SEG_LIMIT;
						SEC_GROUP1: s_nxt.op = OP_GROUP1;
						SEC_GROUP0: s_nxt.op = OP_GROUP0;
						default: begin
							s_nxt.illegal = 1'b1;
							s_nxt.st = ST_FIRST;
						end
					endcase
				end
				default: begin
					// A ModR/M byte that names no supported form.
					s_nxt.illegal = 1'b1;
					s_nxt.st = ST_FIRST;
				end
			endcase
		end else if (s_r.st == ST_EXEC && tmr.last) begin
			s_nxt.done = 1'b1;
			s_nxt.st = ST_FIRST;
		end
		// Prefix flags apply to one instruction, then fall away.
		if (s_nxt.done || s_nxt.illegal) begin
			s_nxt.addr_flip = 1'b0;
			s_nxt.opnd_flip = 1'b0;
		end
	end

	// State register.
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	csid_exec_timer u_timer (
		.clk(CORE_CLK),
		.rst(SYS_RST),
		.t(tmr)
	);

	assign BUSY = s_r.st == ST_EXEC;
	assign EA_REQ = s_r.ea;
	assign INSTR_DONE = s_r.done;
	assign INSTR_ILLEGAL = s_r.illegal;
	assign INSTR_OP = s_r.op;
	assign INSTR_MEM = s_r.mem;
	assign INSTR_ADDR_FLIP = s_r.addr_out;
	assign INSTR_OPND_FLIP = s_r.opnd_out;
	assign INSTR_CYCLES = s_r.cycles;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_addr_prefix: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST) take && s_r.st == ST_FIRST
		&& BYTE_DATA == BYTE_ADDR_FLIP |=> s_r.addr_flip && BYTE_READY)
		else $error("Address prefix not taken in one cycle.");
	a_opnd_prefix: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST) take && s_r.st == ST_FIRST
		&& BYTE_DATA == BYTE_OPND_FLIP |=> s_r.opnd_flip && BYTE_READY)
		else $error("Operand prefix not taken in one cycle.");
	a_cr_load: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		fire && fire_op == OP_CR_WR |=> !BYTE_READY [*4] ##1 INSTR_DONE)
		else $error("Control load not five cycles.");
	a_cr_store: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		fire && fire_op == OP_CR_RD |=> INSTR_DONE && BYTE_READY)
		else $error("Control store not one cycle.");
	a_dr_moves: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		fire && fire_op == OP_DR_RD |-> ##3 INSTR_DONE)
		else $error("Debug store not three cycles.");
	a_clr_ts_time: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		fire && fire_op == OP_CLR_TS |-> ##5 INSTR_DONE)
		else $error("Clear task switched not five cycles.");
	a_adj_slow: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		fire && fire_op == OP_ADJ_PRIV && !fire_mem && EXEC_SLOW
		|-> ##10 INSTR_DONE)
		else $error("Privilege adjust max wrong.");
	a_global_time: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST) fire && fire_op == OP_GLOBAL
		|-> ##4 INSTR_DONE && INSTR_MEM)
		else $error("Global table load not four cycles.");
	a_task_mem: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		fire && fire_op == OP_TASK && fire_mem |-> ##9 INSTR_DONE)
		else $error("Task load from memory not nine.");
	a_lat_match: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
		INSTR_DONE |-> s_r.lat == INSTR_CYCLES)
		else $error("Completion latency differs from count.");
	a_form_select: assert property (@(posedge CORE_CLK)
		disable iff (SYS_RST) fire && s_r.st == ST_MODRM
		|=> INSTR_MEM == ($past(BYTE_DATA[MOD_HI:MOD_LO]) != MOD_REGISTER)
		&& EA_REQ == INSTR_MEM)
		else $error("Operand form wrong.");

	c_prefixed: cover property (@(posedge CORE_CLK)
		INSTR_DONE && INSTR_ADDR_FLIP && INSTR_OPND_FLIP);
	c_msw_mem: cover property (@(posedge CORE_CLK)
		fire && fire_op == OP_MSW && fire_mem);
	c_local_reg: cover property (@(posedge CORE_CLK)
		fire && fire_op == OP_LOCAL && !fire_mem);
	c_illegal: cover property (@(posedge CORE_CLK) INSTR_ILLEGAL);

endmodule

// ===== dv/csid_tb.sv
// Self-checking testbench for the system-instruction decode unit.
module testbench
	import csid_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------------------------------
	// Stimulus and observation signals
	// ----------------------------------------------------------------
	logic CORE_CLK = 1'b0; // Core clock, 100 MHz.
	logic SYS_RST = 1'b1; // Reset held from time zero.
	logic BYTE_VALID = 1'b0; // Fetch offers a byte.
	logic [7:0] BYTE_DATA = 8'h00; // Offered byte.
	logic EXEC_SLOW = 1'b0; // Selects the maximum count.
	logic BYTE_READY, BUSY, EA_REQ, INSTR_DONE, INSTR_ILLEGAL;
	logic [3:0] INSTR_OP, INSTR_CYCLES;
	logic INSTR_MEM, INSTR_ADDR_FLIP, INSTR_OPND_FLIP;
	int err_total = 0; // Mismatches seen.
	int compares = 0; // Comparisons made.

	csid_decode u_dut (.CORE_CLK(CORE_CLK), .SYS_RST(SYS_RST),
		.BYTE_VALID(BYTE_VALID), .BYTE_DATA(BYTE_DATA),
		.EXEC_SLOW(EXEC_SLOW), .BYTE_READY(BYTE_READY), .BUSY(BUSY),
		.EA_REQ(EA_REQ), .INSTR_DONE(INSTR_DONE),
		.INSTR_ILLEGAL(INSTR_ILLEGAL), .INSTR_OP(INSTR_OP),
		.INSTR_MEM(INSTR_MEM), .INSTR_ADDR_FLIP(INSTR_ADDR_FLIP),
		.INSTR_OPND_FLIP(INSTR_OPND_FLIP), .INSTR_CYCLES(INSTR_CYCLES));

	// Free-running clock, 10 ns period.
	initial begin
		forever #5 CORE_CLK = ~CORE_CLK;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	// Compares with case equality so an unknown never passes.
	task automatic check(input string nm, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// Prints the counts and the verdict, then stops the run.
	task automatic complete_run();
		$display("Comparisons %0d, mismatches %0d", compares, err_total);
		if (err_total == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// Offers one byte at the falling edge; it is taken at the next rise.
	task automatic send(input logic [7:0] b, input logic slow);
		@(negedge CORE_CLK);
		check("ready_before_byte", BYTE_READY, 1'b1);
		BYTE_VALID = 1'b1;
		BYTE_DATA = b;
		EXEC_SLOW = slow;
		@(posedge CORE_CLK);
	endtask

	// Feeds a whole instruction, then counts edges until completion.
	// The ready_vs_busy check also proves the byte port refuses while stalled.
	task automatic run_op(input logic [7:0] b0, b1, b2, b3, input int nb,
		input logic slow, input logic [3:0] op, input logic mem,
		input logic [3:0] cyc, input logic af, input logic of);
		logic [7:0] b[4];
		int k;
		int bsy;
		logic ea;
		b = '{b0, b1, b2, b3};
		k = 0;
		bsy = 0;
		ea = 1'b0;
		for (int i = 0; i < nb; i++) begin
			send(b[i], slow);
		end
		// Pass k looks at the cycle after the k-th edge past the final byte.
		do begin
			@(negedge CORE_CLK);
			BYTE_VALID = 1'b0;
			k++;
			if (k == 1 && EA_REQ === 1'b1) ea = 1'b1;
			if (BUSY === 1'b1) bsy++;
			check("ready_vs_busy", BYTE_READY, !BUSY);
		end while (k < 16 && INSTR_DONE !== 1'b1);
		check("cycles_to_done", k[7:0], {4'h0, cyc});
		check("busy_cycles", bsy[7:0], {4'h0, cyc} - 8'h01);
		check("op", {4'h0, INSTR_OP}, {4'h0, op});
		check("mem_form", INSTR_MEM, mem);
		check("ea_pulse", ea, mem);
		check("cycles_out", {4'h0, INSTR_CYCLES}, {4'h0, cyc});
		check("addr_flip", INSTR_ADDR_FLIP, af);
		check("opnd_flip", INSTR_OPND_FLIP, of);
		check("illegal_quiet", INSTR_ILLEGAL, 1'b0);
		@(negedge CORE_CLK);
		check("done_one_cycle", INSTR_DONE, 1'b0);
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset values, then a reset that lands in mid-stall.
	task automatic t_reset();
		check("rst_ready", BYTE_READY, 1'b1);
		check("rst_busy", BUSY, 1'b0);
		check("rst_op", {4'h0, INSTR_OP}, 8'h00);
		send(8'h0f, 1'b0);
		send(8'h00, 1'b0);
		send(8'hd8, 1'b0);
		@(negedge CORE_CLK);
		BYTE_VALID = 1'b0;
		@(negedge CORE_CLK);
		SYS_RST = 1'b1;
		@(negedge CORE_CLK);
		SYS_RST = 1'b0;
		check("mid_rst_busy", BUSY, 1'b0);
		check("mid_rst_done", INSTR_DONE, 1'b0);
		$display("Test reset done");
	endtask

	// Width prefixes cost one cycle each and apply to one op only.
	task automatic t_prefix();
		run_op(8'h67, 8'h0f, 8'h20, 8'hc0, 4, 0, OP_CR_RD, 0, 1, 1, 0);
		run_op(8'h66, 8'h0f, 8'h20, 8'hc0, 4, 0, OP_CR_RD, 0, 1, 0, 1);
		run_op(8'h66, 8'h67, 8'h63, 8'hc0, 4, 0, OP_ADJ_PRIV, 0, 8, 1, 1);
		run_op(8'h0f, 8'h20, 8'hc0, 0, 3, 0, OP_CR_RD, 0, 1, 0, 0);
		$display("Test prefix done");
	endtask

	// Control and debug register moves and the task-switched clear.
	task automatic t_ctrl();
		run_op(8'h0f, 8'h22, 8'hc0, 0, 3, 0, OP_CR_WR, 0, 5, 0, 0);
		run_op(8'h0f, 8'h23, 8'hc0, 0, 3, 0, OP_DR_WR, 0, 4, 0, 0);
		run_op(8'h0f, 8'h23, 8'hf8, 0, 3, 0, OP_DR_WR, 0, 4, 0, 0);
		run_op(8'h0f, 8'h21, 8'hc0, 0, 3, 0, OP_DR_RD, 0, 3, 0, 0);
		run_op(8'h0f, 8'h21, 8'hf0, 0, 3, 0, OP_DR_RD, 0, 3, 0, 0);
		run_op(8'h0f, 8'h06, 0, 0, 2, 0, OP_CLR_TS, 0, 5, 0, 0);
		$display("Test control done");
	endtask

	// Min/max ops in both forms and speeds, bar privilege adjust register at min; mod 01 and 10 too.
	task automatic t_protect();
		run_op(8'h63, 8'hc0, 0, 0, 2, 1, OP_ADJ_PRIV, 0, 10, 0, 0);
		run_op(8'h63, 8'h00, 0, 0, 2, 0, OP_ADJ_PRIV, 1, 6, 0, 0);
		run_op(8'h63, 8'h80, 0, 0, 2, 1, OP_ADJ_PRIV, 1, 8, 0, 0);
		run_op(8'h0f, 8'h02, 8'hc0, 0, 3, 0, OP_ACC_RIGHTS, 0, 3, 0, 0);
		run_op(8'h0f, 8'h02, 8'hc8, 0, 3, 1, OP_ACC_RIGHTS, 0, 5, 0, 0);
		run_op(8'h0f, 8'h02, 8'h00, 0, 3, 0, OP_ACC_RIGHTS, 1, 5, 0, 0);
		run_op(8'h0f, 8'h02, 8'h40, 0, 3, 1, OP_ACC_RIGHTS, 1, 7, 0, 0);
		run_op(8'h0f, 8'h03, 8'hc0, 0, 3, 0, OP_SEG_LIMIT, 0, 3, 0, 0);
		run_op(8'h0f, 8'h03, 8'hc0, 0, 3, 1, OP_SEG_LIMIT, 0, 7, 0, 0);
		run_op(8'h0f, 8'h03, 8'h40, 0, 3, 0, OP_SEG_LIMIT, 1, 5, 0, 0);
		run_op(8'h0f, 8'h03, 8'hbf, 0, 3, 1, OP_SEG_LIMIT, 1, 9, 0, 0);
		$display("Test protect done");
	endtask

	// Descriptor table, status word and task register loads.
	task automatic t_tables();
		run_op(8'h0f, 8'h01, 8'h10, 0, 3, 0, OP_GLOBAL, 1, 4, 0, 0);
		run_op(8'h0f, 8'h01, 8'h18, 0, 3, 1, OP_INTR, 1, 4, 0, 0);
		run_op(8'h0f, 8'h00, 8'hd0, 0, 3, 0, OP_LOCAL, 0, 5, 0, 0);
		run_op(8'h0f, 8'h00, 8'hd0, 0, 3, 1, OP_LOCAL, 0, 8, 0, 0);
		run_op(8'h0f, 8'h00, 8'h50, 0, 3, 0, OP_LOCAL, 1, 6, 0, 0);
		run_op(8'h0f, 8'h00, 8'h90, 0, 3, 1, OP_LOCAL, 1, 9, 0, 0);
		run_op(8'h0f, 8'h01, 8'hf0, 0, 3, 0, OP_MSW, 0, 5, 0, 0);
		run_op(8'h0f, 8'h01, 8'h30, 0, 3, 0, OP_MSW, 1, 7, 0, 0);
		run_op(8'h0f, 8'h00, 8'hd8, 0, 3, 0, OP_TASK, 0, 8, 0, 0);
		run_op(8'h0f, 8'h00, 8'h98, 0, 3, 0, OP_TASK, 1, 9, 0, 0);
		$display("Test tables done");
	endtask

	// Rejected sequences; a prefix must not leak past a rejection.
	task automatic t_illegal();
		send(8'h0f, 1'b0);
		send(8'h22, 1'b0);
		send(8'h00, 1'b0);
		@(negedge CORE_CLK);
		BYTE_VALID = 1'b0;
		check("cr_mem_rejected", INSTR_ILLEGAL, 1'b1);
		send(8'h0f, 1'b0);
		send(8'h01, 1'b0);
		send(8'hd0, 1'b0);
		@(negedge CORE_CLK);
		BYTE_VALID = 1'b0;
		check("global_reg_rejected", INSTR_ILLEGAL, 1'b1);
		send(8'h66, 1'b0);
		send(8'hf4, 1'b0);
		@(negedge CORE_CLK);
		BYTE_VALID = 1'b0;
		check("halt_rejected", INSTR_ILLEGAL, 1'b1);
		run_op(8'h0f, 8'h20, 8'hc0, 0, 3, 0, OP_CR_RD, 0, 1, 0, 0);
		$display("Test illegal done");
	endtask

	// ----------------------------------------------------------------
	// Main sequence and timeout guard
	// ----------------------------------------------------------------
	// Reset spans 12 cycles and is released off the sampling edge.
	initial begin
		repeat (12) @(negedge CORE_CLK);
		SYS_RST = 1'b0;
		t_reset();
		t_prefix();
		t_ctrl();
		t_protect();
		t_tables();
		t_illegal();
		complete_run();
	end

	// About 40 instructions of at most 15 cycles each; ten times that.
	initial begin
		#60000;
		err_total++;
		$display("Timeout expired");
		complete_run();
	end
endmodule
